// ==== base_window_reg.sv ====
`timescale 1ns/100ps
module base_window_reg
  import pci_hdr_pkg::*;
#(
  parameter int WIN_BITS = 8,
  parameter logic [31:0] LOW_CONST = 32'h00000000
) (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // configuration write into this register
  input wire logic wrEn,
  input wire logic [3:0] be,
  input wire logic [31:0] wdata,
  // decode
  input wire logic spaceEn,
  input wire bus_addr_t acc,
  output logic [31:0] barValue,
  output logic hit_ff
);

  // the lane loop and the hardwired low field need between 4 and 31 window bits
  if (WIN_BITS < 4 || WIN_BITS > 31) begin : g_bad_win
    $error("base_window_reg: WIN_BITS out of range");
  end

  logic [31:WIN_BITS] base_ff;
  logic [31:WIN_BITS] nxt_base;
  logic nxt_hit;

  // only bytes whose enable is set change; low bits stay hardwired
  always_comb begin
    nxt_base = base_ff;
    for (int i = WIN_BITS; i < 32; i++) begin
      if (wrEn && be[i / 8]) begin
        nxt_base[i] = wdata[i];
      end
    end
    nxt_hit = acc.valid && spaceEn && (acc.addr[31:WIN_BITS] == base_ff);
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      base_ff <= '0;
      hit_ff <= 1'b0;
    end else begin
      base_ff <= nxt_base;
      hit_ff <= nxt_hit;
    end
  end

  assign barValue = {base_ff, LOW_CONST[WIN_BITS-1:0]};

endmodule : base_window_reg

// ==== bist_local_model.sv ====
`timescale 1ns/100ps
// ****************************************************************
// local-side self test responder
// ****************************************************************
module bist_local_model
  import pci_hdr_pkg::*;
#(
  parameter int DLY = 20,
  parameter logic [3:0] CODE = 4'h5
) (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // self test handshake
  input wire logic startIrq,
  output bist_report_t rep
);
  int cnt;

  // count down after the start pulse, then report done with a code
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cnt <= 0;
      rep <= '{done: 1'b0, code: 4'ha};
    end else begin
      // code is junk outside done so the block must never trust it there
      if (!startIrq && cnt == 1) begin
        rep <= '{done: 1'b1, code: CODE};
      end else begin
        rep <= '{done: 1'b0, code: ~rep.code};
      end
      if (startIrq) begin
        cnt <= DLY;
      end else if (cnt == 1) begin
        cnt <= 0;
      end else if (cnt > 1) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule : bist_local_model

// ==== pci_hdr_pkg.sv ====
package pci_hdr_pkg;

  // ****************************************************************
  // register byte offsets in configuration space
  // ****************************************************************
  localparam logic [7:0] HEADER_LAYOUT_KIND_OFS = 8'h0e;
  localparam logic [7:0] SELF_TEST_CONTROL_OFS = 8'h0f;
  localparam logic [7:0] LOCAL_CONFIG_MEMORY_BASE_OFS = 8'h10;
  localparam logic [7:0] LOCAL_CONFIG_IO_BASE_OFS = 8'h14;

  // ****************************************************************
  // field positions and fixed values
  // ****************************************************************
  localparam int LAYOUT_MSB = 6;
  localparam int MULTI_FUNC_BIT = 7;
  localparam int BIST_CODE_MSB = 3;
  localparam int BIST_START_BIT = 6;
  localparam int BIST_SUPPORT_BIT = 7;
  localparam logic [6:0] LAYOUT_KIND_VAL = 7'h00;
  localparam logic MULTI_FUNC_VAL = 1'b0;
  localparam logic [1:0] BIST_RSVD_VAL = 2'h0;
  localparam logic [3:0] BIST_CODE_RST = 4'h0;
  localparam logic BIST_SUPPORT_RST = 1'b0;
  // low bits of the memory base: space 0, location 00, not prefetchable
  localparam logic [31:0] MEM_BASE_LOW = 32'h00000000;
  // low bits of the i/o base: space indicator 1
  localparam logic [31:0] IO_BASE_LOW = 32'h00000001;
  localparam int MEM_WIN_BITS = 8;
  localparam int IO_WIN_BITS = 8;
  localparam logic [31:0] CFG_ZERO = 32'h00000000;

  // ****************************************************************
  // carriers and states
  // ****************************************************************
  typedef struct packed {
    logic wr;
    logic rd;
    logic [5:0] dwIdx;
    logic [3:0] be;
    logic [31:0] wdata;
  } cfg_req_t;

  typedef struct packed {
    logic valid;
    logic [31:0] addr;
  } bus_addr_t;

  typedef struct packed {
    logic done;
    logic [3:0] code;
  } bist_report_t;

  typedef enum logic {
    BIST_IDLE = 1'b0,
    BIST_RUN = 1'b1
  } bist_state_t;

endpackage : pci_hdr_pkg

// ==== pci_header_bist_base_window.sv ====
`timescale 1ns/100ps
module pci_header_bist_base_window
  import pci_hdr_pkg::*;
#(
  parameter logic BIST_SUPPORTED = 1'b0
) (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // configuration access from the host bus
  input wire cfg_req_t cfgReq,
  output logic [31:0] cfgRdData_ff,
  output logic cfgRdValid_ff,
  // command register enables
  input wire logic memSpaceEn,
  input wire logic ioSpaceEn,
  // host bus addresses to decode
  input wire bus_addr_t memAcc,
  input wire bus_addr_t ioAcc,
  output logic memHit_ff,
  output logic ioHit_ff,
  // local side self test
  input wire bist_report_t bistReport,
  output logic bistStartIrq_ff,
  output logic bistActive_ff
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [5:0] dwOf(input logic [7:0] ofs);
    dwOf = ofs[7:2];
  endfunction : dwOf

  localparam logic [5:0] HDR_DW = dwOf(HEADER_LAYOUT_KIND_OFS);
  localparam logic [5:0] MEM_DW = dwOf(LOCAL_CONFIG_MEMORY_BASE_OFS);
  localparam logic [5:0] IO_DW = dwOf(LOCAL_CONFIG_IO_BASE_OFS);
  localparam int START_POS = 8 * int'(SELF_TEST_CONTROL_OFS[1:0]) + BIST_START_BIT;
  localparam int START_LANE = int'(SELF_TEST_CONTROL_OFS[1:0]);

  // ****************************************************************
  // state
  // ****************************************************************
  bist_state_t state_ff;
  bist_state_t nxt_state;
  logic [3:0] code_ff;
  logic [3:0] nxt_code;
  logic support_ff;
  logic nxt_support;
  logic nxt_irq;
  logic nxt_active;
  logic [31:0] nxt_rdData;
  logic nxt_rdValid;
  logic [5:0] lastRdIdx_ff;
  logic [5:0] nxt_lastRdIdx;
  logic [31:0] memBar;
  logic [31:0] ioBar;
  logic startReq;
  logic [7:0] hdrByte;
  logic [7:0] bistByte;

  // both bytes are constant or local state; host writes reach only the start bit, through the self test state
  assign hdrByte = {MULTI_FUNC_VAL, LAYOUT_KIND_VAL};
  assign bistByte = {support_ff, (state_ff == BIST_RUN), BIST_RSVD_VAL, code_ff};
  assign startReq = cfgReq.wr && (cfgReq.dwIdx == HDR_DW) && cfgReq.be[START_LANE]
                    && cfgReq.wdata[START_POS];

  // ****************************************************************
  // base address registers
  // ****************************************************************
  // memory window onto the local configuration registers
  base_window_reg #(
    .WIN_BITS(MEM_WIN_BITS),
    .LOW_CONST(MEM_BASE_LOW)
  ) u_mem_base (
    .mclk(mclk),
    .resetn(resetn),
    .wrEn(cfgReq.wr && (cfgReq.dwIdx == MEM_DW)),
    .be(cfgReq.be),
    .wdata(cfgReq.wdata),
    .spaceEn(memSpaceEn),
    .acc(memAcc),
    .barValue(memBar),
    .hit_ff(memHit_ff)
  );

  // i/o window onto the same registers
  base_window_reg #(
    .WIN_BITS(IO_WIN_BITS),
    .LOW_CONST(IO_BASE_LOW)
  ) u_io_base (
    .mclk(mclk),
    .resetn(resetn),
    .wrEn(cfgReq.wr && (cfgReq.dwIdx == IO_DW)),
    .be(cfgReq.be),
    .wdata(cfgReq.wdata),
    .spaceEn(ioSpaceEn),
    .acc(ioAcc),
    .barValue(ioBar),
    .hit_ff(ioHit_ff)
  );

  // ****************************************************************
  // self test control
  // ****************************************************************
  // a start that lands with the done report wins: test restarts
  always_comb begin
    nxt_state = state_ff;
    nxt_code = code_ff;
    nxt_irq = 1'b0;
    nxt_support = BIST_SUPPORTED; // strap taken after reset release
    unique case (state_ff)
      BIST_IDLE: begin
        if (startReq) begin
          nxt_state = BIST_RUN;
          nxt_irq = 1'b1;
        end
      end
      BIST_RUN: begin
        if (bistReport.done) begin
          nxt_code = bistReport.code;
          if (!startReq) begin
            nxt_state = BIST_IDLE;
          end else begin
            nxt_irq = 1'b1;
          end
        end
      end
    endcase
    // the local side sees the same level that the host reads as the start bit
    nxt_active = (nxt_state == BIST_RUN);
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_ff <= BIST_IDLE;
      code_ff <= BIST_CODE_RST;
      support_ff <= BIST_SUPPORT_RST;
      bistStartIrq_ff <= 1'b0;
      bistActive_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      code_ff <= nxt_code;
      support_ff <= nxt_support;
      bistStartIrq_ff <= nxt_irq;
      bistActive_ff <= nxt_active;
    end
  end

  // ****************************************************************
  // configuration read
  // ****************************************************************
  // unmapped dwords and bytes outside this block read zero
  always_comb begin
    nxt_rdValid = cfgReq.rd;
    nxt_rdData = CFG_ZERO;
    // index kept only so the checks know which dword answered
    nxt_lastRdIdx = cfgReq.dwIdx;
    if (cfgReq.rd) begin
      if (cfgReq.dwIdx == HDR_DW) begin
        nxt_rdData = {bistByte, hdrByte, 16'h0000};
      end else if (cfgReq.dwIdx == MEM_DW) begin
        nxt_rdData = memBar;
      end else if (cfgReq.dwIdx == IO_DW) begin
        nxt_rdData = ioBar;
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cfgRdData_ff <= CFG_ZERO;
      cfgRdValid_ff <= 1'b0;
      lastRdIdx_ff <= 6'h00;
    end else begin
      cfgRdData_ff <= nxt_rdData;
      cfgRdValid_ff <= nxt_rdValid;
      lastRdIdx_ff <= nxt_lastRdIdx;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  a_header_byte_zero: assert property (
    @(posedge mclk) disable iff (!resetn)
    cfgRdValid_ff && (lastRdIdx_ff == HDR_DW) |-> cfgRdData_ff[23:16] == 8'h00
  ) else $error("header type byte not zero");

  a_bist_start_irq: assert property (
    @(posedge mclk) disable iff (!resetn)
    (state_ff == BIST_IDLE) && startReq |=> bistStartIrq_ff && bistActive_ff
  ) else $error("start write did not raise local interrupt");

  a_bist_irq_pulse: assert property (
    @(posedge mclk) disable iff (!resetn)
    bistStartIrq_ff && !$past(startReq) |-> 1'b0
  ) else $error("local interrupt without start write");

  a_bist_done_clear: assert property (
    @(posedge mclk) disable iff (!resetn)
    (state_ff == BIST_RUN) && bistReport.done && !startReq
    |=> !bistActive_ff && !bistByte[BIST_START_BIT]
  ) else $error("start bit not cleared after done");

  a_bist_code_hold: assert property (
    @(posedge mclk) disable iff (!resetn)
    !bistReport.done |=> $stable(code_ff)
  ) else $error("self-test code changed without local report");

  a_support_fixed: assert property (
    @(posedge mclk) disable iff (!resetn)
    cfgRdValid_ff && (lastRdIdx_ff == HDR_DW) && $past(resetn, 2)
    |-> cfgRdData_ff[31] == BIST_SUPPORTED
  ) else $error("self-test support bit wrong");

  a_mem_base_low: assert property (
    @(posedge mclk) disable iff (!resetn)
    cfgRdValid_ff && (lastRdIdx_ff == MEM_DW) |-> cfgRdData_ff[7:0] == 8'h00
  ) else $error("memory base low byte not hardwired");

  a_io_space_bit: assert property (
    @(posedge mclk) disable iff (!resetn)
    cfgRdValid_ff && (lastRdIdx_ff == IO_DW) |-> cfgRdData_ff[1:0] == 2'b01
  ) else $error("i/o base space bit not one");

  // compare with the base as it stood when the address was taken
  a_mem_claim: assert property (
    @(posedge mclk) disable iff (!resetn)
    memHit_ff |-> $past(memAcc.valid) && $past(memSpaceEn)
                  && ($past(memAcc.addr[31:MEM_WIN_BITS]) == $past(memBar[31:MEM_WIN_BITS]))
  ) else $error("memory window claimed without match");

  a_mem_claim_taken: assert property (
    @(posedge mclk) disable iff (!resetn)
    memAcc.valid && memSpaceEn
    && (memAcc.addr[31:MEM_WIN_BITS] == memBar[31:MEM_WIN_BITS]) |=> memHit_ff
  ) else $error("matching memory access not claimed");

  a_io_claim: assert property (
    @(posedge mclk) disable iff (!resetn)
    ioHit_ff |-> $past(ioAcc.valid) && $past(ioSpaceEn)
                 && ($past(ioAcc.addr[31:IO_WIN_BITS]) == $past(ioBar[31:IO_WIN_BITS]))
  ) else $error("i/o window claimed without match");

  a_base_write: assert property (
    @(posedge mclk) disable iff (!resetn)
    cfgReq.wr && (cfgReq.dwIdx == MEM_DW) && (cfgReq.be == 4'hf) && !cfgReq.rd
    |=> memBar[31:8] == $past(cfgReq.wdata[31:8])
  ) else $error("memory base upper bits not written");

  // a lane without its enable keeps its old byte
  a_base_lane_keep: assert property (
    @(posedge mclk) disable iff (!resetn)
    cfgReq.wr && (cfgReq.dwIdx == MEM_DW) && !cfgReq.be[1]
    |=> memBar[15:8] == $past(memBar[15:8])
  ) else $error("memory base byte changed without its enable");

  a_io_base_write: assert property (
    @(posedge mclk) disable iff (!resetn)
    cfgReq.wr && (cfgReq.dwIdx == IO_DW) && (cfgReq.be == 4'hf)
    |=> ioBar[31:IO_WIN_BITS] == $past(cfgReq.wdata[31:IO_WIN_BITS])
  ) else $error("i/o base upper bits not written");

  // self test: busy starts are dropped, the code only moves with done
  a_start_busy_ignored: assert property (
    @(posedge mclk) disable iff (!resetn)
    (state_ff == BIST_RUN) && startReq && !bistReport.done |=> !bistStartIrq_ff
  ) else $error("start during running self test raised interrupt");

  a_code_captured: assert property (
    @(posedge mclk) disable iff (!resetn)
    (state_ff == BIST_RUN) && bistReport.done |=> code_ff == $past(bistReport.code)
  ) else $error("self-test code not taken with done");

  a_start_bit_read: assert property (
    @(posedge mclk) disable iff (!resetn)
    cfgRdValid_ff && (lastRdIdx_ff == HDR_DW)
    |-> cfgRdData_ff[START_POS] == $past(bistActive_ff)
  ) else $error("start bit read back differs from local active level");

  // read port: every strobe answered, holes read zero
  a_rd_answer: assert property (
    @(posedge mclk) disable iff (!resetn)
    cfgReq.rd |=> cfgRdValid_ff
  ) else $error("configuration read not answered");

  a_unmapped_zero: assert property (
    @(posedge mclk) disable iff (!resetn)
    cfgRdValid_ff && (lastRdIdx_ff != HDR_DW) && (lastRdIdx_ff != MEM_DW)
    && (lastRdIdx_ff != IO_DW) |-> cfgRdData_ff == CFG_ZERO
  ) else $error("unmapped dword did not read zero");

endmodule : pci_header_bist_base_window

// ==== pci_header_bist_base_window_tb_top.sv ====
`timescale 1ns/100ps
module pci_header_bist_base_window_tb_top
  import pci_hdr_pkg::*;
;
  logic mclk;
  logic resetn;
  cfg_req_t cfgReq;
  logic [31:0] cfgRdData_ff;
  logic cfgRdValid_ff, memSpaceEn, ioSpaceEn, memHit_ff, ioHit_ff;
  logic bistStartIrq_ff, bistActive_ff;
  bus_addr_t memAcc, ioAcc;
  bist_report_t bistReport;
  int n_mismatch = 0;
  int check_count = 0;
  localparam int DONE_DLY = 20;

  pci_header_bist_base_window uut (.mclk, .resetn, .cfgReq, .cfgRdData_ff, .cfgRdValid_ff,
    .memSpaceEn, .ioSpaceEn, .memAcc, .ioAcc, .memHit_ff, .ioHit_ff, .bistReport,
    .bistStartIrq_ff, .bistActive_ff);

  bist_local_model #(.DLY(DONE_DLY), .CODE(4'h5)) partner (.mclk, .resetn,
    .startIrq(bistStartIrq_ff), .rep(bistReport));

  // ****************************************************************
  // clock, compares and verdict
  // ****************************************************************
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic chk32(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : chk32

  task automatic chk1(input string name, input logic exp, input logic got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %b seen %b", name, exp, got);
    end
  endtask : chk1

  task automatic give_verdict;
    $display("mismatches %0d of %0d checks", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict

  // ****************************************************************
  // access tasks: one-cycle strobes, answer one edge after taking
  // ****************************************************************
  task automatic wr(input logic [5:0] idx, input logic [3:0] be, input logic [31:0] d);
    @(posedge mclk);
    cfgReq <= '{wr: 1'b1, rd: 1'b0, dwIdx: idx, be: be, wdata: d};
    @(posedge mclk);
    cfgReq <= '0;
    #1;
  endtask : wr

  task automatic rd_chk(input logic [5:0] idx, input logic [31:0] exp, input string name);
    @(posedge mclk);
    cfgReq <= '{wr: 1'b0, rd: 1'b1, dwIdx: idx, be: 4'hf, wdata: 32'h0};
    @(posedge mclk);
    cfgReq <= '0;
    #1;
    chk1("rdValid", 1'b1, cfgRdValid_ff);
    chk32(name, exp, cfgRdData_ff);
  endtask : rd_chk

  // one decode cycle on either window, hit looked at one cycle later
  task automatic dec(input logic io, input logic [31:0] a, input logic en, input logic exp);
    @(posedge mclk);
    if (io) begin
      ioAcc <= '{1'b1, a};
      ioSpaceEn <= en;
    end else begin
      memAcc <= '{1'b1, a};
      memSpaceEn <= en;
    end
    @(posedge mclk);
    memAcc <= '0;
    ioAcc <= '0;
    #1;
    chk1(io ? "ioHit" : "memHit", exp, io ? ioHit_ff : memHit_ff);
  endtask : dec

  // watchdog: the whole run needs about 130 cycles
  initial begin
    repeat (5000) @(posedge mclk);
    n_mismatch++;
    give_verdict;
  end

  // ****************************************************************
  // test sequence
  // ****************************************************************
  initial begin
    resetn = 1'b0;
    cfgReq = '0;
    memSpaceEn = 1'b0;
    ioSpaceEn = 1'b0;
    memAcc = '0;
    ioAcc = '0;
    repeat (8) @(posedge mclk);
    resetn <= 1'b1;
    rd_chk(6'h03, 32'h00000000, "hdrBist");
    rd_chk(6'h04, 32'h00000000, "memBase");
    rd_chk(6'h05, 32'h00000001, "ioBase");
    rd_chk(6'h3f, 32'h00000000, "unmapped");
    // all ones: only the start bit may stick
    wr(6'h03, 4'hf, 32'hffffffff);
    chk1("startIrq", 1'b1, bistStartIrq_ff);
    chk1("active", 1'b1, bistActive_ff);
    @(posedge mclk);
    #1;
    chk1("startIrq", 1'b0, bistStartIrq_ff);
    rd_chk(6'h03, 32'h40000000, "hdrBist");
    // bounded wait stands in for the host's give-up time
    for (int i = 0; i < 100 && bistActive_ff !== 1'b0; i++) @(posedge mclk);
    #1;
    chk1("active", 1'b0, bistActive_ff);
    rd_chk(6'h03, 32'h05000000, "hdrBist");
    // lane 3 disabled: the start bit must not stick
    wr(6'h03, 4'h7, 32'hffffffff);
    chk1("active", 1'b0, bistActive_ff);
    // second start lands on the edge that takes done: set wins, test restarts
    wr(6'h03, 4'h8, 32'h40000000);
    repeat (DONE_DLY) @(posedge mclk);
    wr(6'h03, 4'h8, 32'h40000000);
    chk1("startIrq", 1'b1, bistStartIrq_ff);
    chk1("active", 1'b1, bistActive_ff);
    // a start while running with no done is dropped
    wr(6'h03, 4'h8, 32'h40000000);
    chk1("startIrq", 1'b0, bistStartIrq_ff);
    rd_chk(6'h03, 32'h45000000, "hdrBist");
    for (int i = 0; i < 100 && bistActive_ff !== 1'b0; i++) @(posedge mclk);
    #1;
    chk1("active", 1'b0, bistActive_ff);
    wr(6'h04, 4'hf, 32'hffffffff);
    rd_chk(6'h04, 32'hffffff00, "memBase");
    wr(6'h05, 4'hf, 32'hffffffff);
    rd_chk(6'h05, 32'hffffff01, "ioBase");
    wr(6'h04, 4'hf, 32'h123456ff);
    rd_chk(6'h04, 32'h12345600, "memBase");
    wr(6'h05, 4'hf, 32'h0000ab00);
    dec(1'b0, 32'h12345644, 1'b1, 1'b1);
    dec(1'b0, 32'h12345644, 1'b0, 1'b0);
    dec(1'b0, 32'h12345744, 1'b1, 1'b0);
    dec(1'b1, 32'h0000abfc, 1'b1, 1'b1);
    dec(1'b1, 32'h0000ab10, 1'b0, 1'b0);
    dec(1'b1, 32'h0000ac10, 1'b1, 1'b0);
    // upper lane alone: lower base bytes keep their value
    wr(6'h04, 4'h8, 32'haaffffff);
    rd_chk(6'h04, 32'haa345600, "memBase");
    // reset in mid-run: bases and self-test byte return to zero
    resetn <= 1'b0;
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    rd_chk(6'h04, 32'h00000000, "memBase");
    rd_chk(6'h05, 32'h00000001, "ioBase");
    rd_chk(6'h03, 32'h00000000, "hdrBist");
    give_verdict;
  end
endmodule : pci_header_bist_base_window_tb_top
